// >>> pdc_counter.sv
/*
 * Programmable down counter that emits one tick per completed count.
 * Assumes step is a one-cycle enable on the bus clock and ratio >= 1.
 */
`timescale 1ns/1ps
module pdc_counter #(
    parameter int WIDTH = 15
) (
    input  wire logic             hclk,
    input  wire logic             hresetn,
    input  wire logic             restart,
    input  wire logic             step,
    input  wire logic [WIDTH-1:0] ratio,
    output logic                  tick,
    output logic [WIDTH-1:0]      count
);
    if (WIDTH < 1 || WIDTH > 16) begin : g_bad_width
        $error("pdc_counter width out of range");
    end

    typedef struct packed {
        logic [WIDTH-1:0] cnt;
    } pdc_cnt_state_t;

    pdc_cnt_state_t st_q;
    pdc_cnt_state_t st_d;
    logic [WIDTH-1:0] reload;

    assign reload = ratio - {{(WIDTH-1){1'b0}}, 1'b1};
    assign tick   = step && !restart && (st_q.cnt == '0);
    assign count  = st_q.cnt;

    always_comb begin
        st_d = st_q;
        if (restart) begin
            st_d.cnt = reload;
        end else if (step) begin
            // Reload on terminal count so the divide never pauses.
            st_d.cnt = (st_q.cnt == '0) ? reload : st_q.cnt - 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end
endmodule // pdc_counter

// >>> pdc_divider_chain.sv
/*
 * Divider chain top: reference divider, dual-modulus prescaler with
 * swallow counter, main feedback counter, phase/frequency detector
 * and an AHB-Lite register slave.
 * Assumes reference and RF pins toggle slower than half the 40 MHz
 * bus clock; every pin edge is sampled, so faster inputs alias.
 */
`timescale 1ns/1ps
module pdc_divider_chain #(
    parameter bit LOW_BAND = 1'b0
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    input  wire logic        reference_in_pin,
    output logic             reference_out_pin,
    input  wire logic        rf_input,
    input  wire logic        prog_clk_pin,
    input  wire logic        prog_data_pin,
    input  wire logic        latch_strobe,
    output logic             pump_up,
    output logic             pump_down
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic        ref_s1, ref_s2, ref_s3, ref_out;
        logic        rf_s1, rf_s2, rf_s3;
        logic [5:0]  psc_cnt;
        logic [4:0]  swallow;
        logic        up, dn, run;
        logic        wr_ctrl;
        logic [31:0] hrdata;
        logic [15:0] fb_cycles;
    } pdc_top_state_t;

    localparam pdc_top_state_t ST_RST = '{
        run: pdc_pkg::RUN_RST, default: '0};

    pdc_top_state_t st_q;
    pdc_top_state_t st_d;

    pdc_prog_if prog ();

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [15:0] pdc_floor(input logic [15:0] v,
                                               input logic [15:0] lo);
        return (v < lo) ? lo : v;
    endfunction

    function automatic logic [5:0] pdc_base(input logic sel);
        if (LOW_BAND) begin
            return sel ? pdc_pkg::MOD_16 : pdc_pkg::MOD_8;
        end
        return sel ? pdc_pkg::MOD_32 : pdc_pkg::MOD_16;
    endfunction

    // ------------------------------------------------------------------
    // Programmed values
    // ------------------------------------------------------------------
    logic [14:0] ref_ratio;
    logic [12:0] main_val;
    logic [4:0]  swl_val;
    logic        psc_sel;
    logic [15:0] ref_eff16;
    logic [15:0] main_eff16;
    logic [14:0] ref_eff;
    logic [12:0] main_eff;
    logic [5:0]  base;
    logic [5:0]  modulus;

    assign ref_ratio  = prog.ref_word[pdc_pkg::REF_LSB +: pdc_pkg::REF_W];
    assign main_val   = prog.fb_word[pdc_pkg::MAIN_LSB +: pdc_pkg::MAIN_W];
    assign swl_val    = prog.fb_word[pdc_pkg::SWL_LSB +: pdc_pkg::SWL_W];
    assign psc_sel    = prog.fb_word[pdc_pkg::PSEL_BIT];

    // Ratios below the divider's floor are raised rather than stalled.
    assign ref_eff16  = pdc_floor({1'b0, ref_ratio}, pdc_pkg::REF_MIN);
    assign main_eff16 = pdc_floor({3'h0, main_val}, pdc_pkg::MAIN_MIN);
    assign ref_eff    = ref_eff16[14:0];
    assign main_eff   = main_eff16[12:0];

    assign base    = pdc_base(psc_sel);
    // Upper modulus while swallowing, base modulus afterwards.
    assign modulus = base + {5'h00, (st_q.swallow != 5'h00)};

    // ------------------------------------------------------------------
    // Edges and divider enables
    // ------------------------------------------------------------------
    logic ref_edge;
    logic rf_edge;
    logic restart;
    logic psc_tick;
    logic ref_tick;
    logic fb_tick;

    assign ref_edge = st_q.ref_s2 && !st_q.ref_s3;
    assign rf_edge  = st_q.rf_s2 && !st_q.rf_s3;
    // A new word or a stopped chain restarts every count from the top.
    assign restart  = prog.load || !st_q.run;
    assign psc_tick = rf_edge && !restart &&
                      (st_q.psc_cnt == modulus - 6'h01);

    // ------------------------------------------------------------------
    // Submodules
    // ------------------------------------------------------------------
    pdc_serial_port u_port (
        .hclk          (hclk),
        .hresetn       (hresetn),
        .prog_clk_pin  (prog_clk_pin),
        .prog_data_pin (prog_data_pin),
        .latch_strobe  (latch_strobe),
        .prog          (prog)
    );

    pdc_counter #(.WIDTH(pdc_pkg::REF_W)) u_ref_div (
        .hclk    (hclk),
        .hresetn (hresetn),
        .restart (restart),
        .step    (ref_edge),
        .ratio   (ref_eff),
        .tick    (ref_tick),
        .count   ()
    );

    pdc_counter #(.WIDTH(pdc_pkg::MAIN_W)) u_fb_div (
        .hclk    (hclk),
        .hresetn (hresetn),
        .restart (restart),
        .step    (psc_tick),
        .ratio   (main_eff),
        .tick    (fb_tick),
        .count   ()
    );

    // ------------------------------------------------------------------
    // Register read decode
    // ------------------------------------------------------------------
    function automatic logic [31:0] pdc_read(input logic [31:0] a,
                                              input pdc_top_state_t s);
        unique case (a)
            pdc_pkg::REG_CTRL:   return {31'h0000_0000, s.run};
            pdc_pkg::REG_STATUS: return {s.fb_cycles, 13'h0000,
                                         (s.swallow != 5'h00), s.dn, s.up};
            pdc_pkg::REG_REF:    return {10'h000, prog.ref_word};
            pdc_pkg::REG_FB:     return {10'h000, prog.fb_word};
            pdc_pkg::REG_AUX:    return {10'h000, prog.aux_word};
            default:             return 32'h0000_0000;
        endcase
    endfunction

    logic take;
    assign take = hsel && htrans[1] && hready;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    logic up_n;
    logic dn_n;

    always_comb begin
        st_d = st_q;
        up_n = 1'b0;
        dn_n = 1'b0;

        st_d.ref_s1  = reference_in_pin;
        st_d.ref_s2  = st_q.ref_s1;
        st_d.ref_s3  = st_q.ref_s2;
        st_d.ref_out = st_q.ref_s2;
        st_d.rf_s1   = rf_input;
        st_d.rf_s2   = st_q.rf_s1;
        st_d.rf_s3   = st_q.rf_s2;

        if (restart) begin
            st_d.psc_cnt = 6'h00;
            st_d.swallow = swl_val;
        end else if (rf_edge) begin
            st_d.psc_cnt = psc_tick ? 6'h00 : st_q.psc_cnt + 6'h01;
            if (fb_tick) begin
                st_d.swallow = swl_val;
            end else if (psc_tick && st_q.swallow != 5'h00) begin
                st_d.swallow = st_q.swallow - 5'h01;
            end
        end

        // Both pulses seen clears both; pulse width tracks phase error.
        if (!st_q.run) begin
            st_d.up = 1'b0;
            st_d.dn = 1'b0;
        end else begin
            up_n    = st_q.up || ref_tick;
            dn_n    = st_q.dn || fb_tick;
            st_d.up = up_n && !dn_n;
            st_d.dn = dn_n && !up_n;
        end

        if (fb_tick) begin
            st_d.fb_cycles = st_q.fb_cycles + 16'h0001;
        end

        if (st_q.wr_ctrl) begin
            st_d.run = hwdata[pdc_pkg::CTRL_RUN_BIT];
        end
        st_d.wr_ctrl = take && hwrite && (haddr == pdc_pkg::REG_CTRL);
        if (take && !hwrite) begin
            st_d.hrdata = pdc_read(haddr, st_q);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q <= ST_RST;
        end else begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Zero wait states: every transfer completes in its data phase.
    assign hreadyout         = 1'b1;
    assign hresp             = 1'b0;
    assign hrdata            = st_q.hrdata;
    assign reference_out_pin = st_q.ref_out;
    assign pump_up           = st_q.up;
    assign pump_down         = st_q.dn;

    // ------------------------------------------------------------------
    // Checking helpers
    // ------------------------------------------------------------------
    logic [15:0] ref_edges_h;
    logic        ref_ok_h;
    logic [18:0] rf_edges_h;
    logic        fb_ok_h;
    logic [18:0] n_total_h;

    assign n_total_h = 19'({13'h0000, base} * {6'h00, main_eff}) +
                       {14'h0000, swl_val};

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ref_edges_h <= 16'h0000;
            ref_ok_h    <= 1'b0;
            rf_edges_h  <= 19'h0_0000;
            fb_ok_h     <= 1'b0;
        end else if (restart) begin
            ref_edges_h <= 16'h0000;
            ref_ok_h    <= 1'b0;
            rf_edges_h  <= 19'h0_0000;
            fb_ok_h     <= 1'b0;
        end else begin
            if (ref_tick) begin
                ref_edges_h <= 16'h0000;
                ref_ok_h    <= 1'b1;
            end else if (ref_edge) begin
                ref_edges_h <= ref_edges_h + 16'h0001;
            end
            if (fb_tick) begin
                rf_edges_h <= 19'h0_0000;
                fb_ok_h    <= 1'b1;
            end else if (rf_edge) begin
                rf_edges_h <= rf_edges_h + 19'h0_0001;
            end
        end
    end

    default clocking pdc_cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    property p_ref_floor;
        ref_tick && ref_ok_h |-> ref_edges_h >= 16'h0001;
    endproperty
    a_ref_floor: assert property (p_ref_floor)
        else $error("reference ratio below two");

    property p_ref_period;
        ref_tick && ref_ok_h |-> ref_edges_h == {1'b0, ref_eff} - 16'h0001;
    endproperty
    a_ref_period: assert property (p_ref_period)
        else $error("reference tick at wrong edge count");

    property p_ref_buf;
        $rose(reference_out_pin) |-> $past(ref_edge);
    endproperty
    a_ref_buf: assert property (p_ref_buf)
        else $error("reference output rose without input edge");

    property p_fb_clk;
        fb_tick |-> psc_tick;
    endproperty
    a_fb_clk: assert property (p_fb_clk)
        else $error("feedback counter stepped without prescaler");

    property p_fb_total;
        fb_tick && fb_ok_h && swl_val <= main_eff && {1'b0, swl_val} < base
        |-> rf_edges_h + 19'h0_0001 == n_total_h;
    endproperty
    a_fb_total: assert property (p_fb_total)
        else $error("feedback ratio differs from base*main+swallow");

    property p_swallow_step;
        !restart && psc_tick && !fb_tick && st_q.swallow != 5'h00
        |=> st_q.swallow == $past(st_q.swallow) - 5'h01;
    endproperty
    a_swallow_step: assert property (p_swallow_step)
        else $error("swallow counter failed to step");

    property p_pfd_excl;
        !(pump_up && pump_down);
    endproperty
    a_pfd_excl: assert property (p_pfd_excl)
        else $error("pump up and down both active");

    property p_pfd_up;
        st_q.run && ref_tick && !fb_tick && !pump_down ##1 st_q.run
        |-> pump_up;
    endproperty
    a_pfd_up: assert property (p_pfd_up)
        else $error("reference pulse did not raise pump up");

    property p_load;
        prog.load |=> st_q.psc_cnt == 6'h00 &&
                      st_q.swallow == $past(swl_val);
    endproperty
    a_load: assert property (p_load)
        else $error("latch load did not restart the prescaler");

endmodule // pdc_divider_chain

// >>> pdc_divider_chain_tb_top.sv
/*
 * Self-checking bench of the divider chain: AHB-Lite master tasks,
 * pin-level division checks and serial programming checks.
 * Assumes the design answers every bus transfer with OKAY.
 */
`timescale 1ns/1ps
module pdc_divider_chain_tb_top;
    localparam int MAX_CYC = 60000;
    logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        ref_pin, rf_pin, pclk, pdata, pstrobe;
    logic        reference_out_pin, pump_up, pump_down;
    int          error_cnt, checked, cyc, seed;

    pdc_divider_chain #(.LOW_BAND(1'b0)) u_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(hresp), .reference_in_pin(ref_pin),
        .reference_out_pin(reference_out_pin), .rf_input(rf_pin),
        .prog_clk_pin(pclk), .prog_data_pin(pdata),
        .latch_strobe(pstrobe), .pump_up(pump_up), .pump_down(pump_down));

    pdc_far_side u_far (
        .hclk(hclk), .reference_in_pin(ref_pin), .rf_input(rf_pin),
        .prog_clk_pin(pclk), .prog_data_pin(pdata),
        .latch_strobe(pstrobe));

    assign hready = hreadyout;
    initial hclk = 1'b0;
    always #12.5 hclk = ~hclk;

    // ------------------------------------------------------------------
    // Checking and closing
    // ------------------------------------------------------------------
    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t register %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_pin(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t pin %b expected %b", $time, got, exp);
        end
    endtask

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == MAX_CYC) begin
            error_cnt++;
            $display("ERROR %0t run did not finish", $time);
            test_done();
        end
    end

    // ------------------------------------------------------------------
    // Bus master and expectations
    // ------------------------------------------------------------------
    task automatic xfer(input logic w, input logic [31:0] a,
                        input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'b10;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        chk_pin(hresp, 1'b0);
        rd = hrdata;
    endtask

    function automatic logic [21:0] fb_word(input logic sel,
            input logic [12:0] main, input logic [4:0] sw);
        return {1'b0, sel, main, sw, pdc_pkg::ADDR_FB};
    endfunction

    // Edges on one pin, then the pump levels once the sync has settled.
    task automatic step(input logic rf, input int cnt,
                        input logic up, input logic dn);
        u_far.edges(rf, cnt);
        repeat (4) @(posedge hclk);
        chk_pin(pump_up, up);
        chk_pin(pump_down, dn);
    endtask

    task automatic run_case(input logic sel, input logic [12:0] main,
            input logic [4:0] sw, input logic [14:0] r, input logic rff);
        logic [31:0] rd, c0;
        int n, nl, nt;
        n = (sel ? pdc_pkg::MOD_32 : pdc_pkg::MOD_16) * main + sw;
        nl = rff ? n : r;
        nt = rff ? r : n;
        u_far.send_word(fb_word(sel, main, sw));
        u_far.send_word({5'h00, r, pdc_pkg::ADDR_REF});
        xfer(1'b0, pdc_pkg::REG_FB, 32'h0, rd);
        chk_reg(rd, {10'h0, fb_word(sel, main, sw)});
        xfer(1'b0, pdc_pkg::REG_REF, 32'h0, rd);
        chk_reg(rd, {10'h0, 5'h00, r, pdc_pkg::ADDR_REF});
        xfer(1'b0, pdc_pkg::REG_STATUS, 32'h0, c0);
        chk_reg({29'h0, c0[2:0]}, {29'h0, sw != 5'h00, 2'b00});
        step(rff, nl - 1, 1'b0, 1'b0);
        step(rff, 1, ~rff, rff);
        step(~rff, nt - 1, ~rff, rff);
        step(~rff, 1, 1'b0, 1'b0);
        xfer(1'b0, pdc_pkg::REG_STATUS, 32'h0, rd);
        chk_reg({16'h0, rd[31:16] - c0[31:16]}, 32'h1);
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        logic [31:0] rd;
        logic [12:0] main;
        logic [4:0]  sw;
        logic [14:0] r;
        logic [21:0] w;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0000_0000;
        error_cnt = 0;
        checked = 0;
        cyc = 0;
        seed = 77387;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        xfer(1'b0, pdc_pkg::REG_CTRL, 32'h0, rd);
        chk_reg(rd, 32'h0000_0001);
        foreach (w[i]) if (i < 5) begin
            xfer(1'b0, 32'h0000_0004 * i + 32'h0000_0004, 32'h0, rd);
            chk_reg(rd, 32'h0000_0000);
        end
        xfer(1'b1, pdc_pkg::REG_REF, 32'hFFFF_FFFF, rd);
        xfer(1'b1, 32'h0000_0040, 32'hFFFF_FFFF, rd);
        xfer(1'b0, pdc_pkg::REG_REF, 32'h0, rd);
        chk_reg(rd, 32'h0000_0000);
        xfer(1'b1, pdc_pkg::REG_CTRL, 32'h0, rd);
        xfer(1'b0, pdc_pkg::REG_CTRL, 32'h0, rd);
        chk_reg(rd, 32'h0000_0000);
        xfer(1'b1, pdc_pkg::REG_CTRL, 32'h0000_0001, rd);
        u_far.reference_in_pin <= 1'b1;
        repeat (4) @(posedge hclk);
        chk_pin(reference_out_pin, 1'b1);
        u_far.reference_in_pin <= 1'b0;
        repeat (4) @(posedge hclk);
        chk_pin(reference_out_pin, 1'b0);
        $display("register and buffer tests done");
        for (int i = 0; i < 6; i++) begin
            main = 13'd1 + 13'($unsigned($random(seed)) % 4);
            // Swallow kept within the main count and the base modulus.
            sw = 5'($unsigned($random(seed)) % (main + 1));
            r = 15'd2 + 15'($unsigned($random(seed)) % 30);
            if (i < 2) begin
                main = 13'd1;
                sw = 5'(i);
                r = 15'd2;
            end
            run_case(i[0], main, sw, r, i[1]);
            $display("division case %0d done", i);
        end
        w = {20'($random(seed)), pdc_pkg::ADDR_AUX};
        u_far.send_word(w);
        u_far.send_word({20'hF_FFFF, 2'b11});
        xfer(1'b0, pdc_pkg::REG_AUX, 32'h0, rd);
        chk_reg(rd, {10'h0, w});
        xfer(1'b0, pdc_pkg::REG_REF, 32'h0, rd);
        chk_reg(rd, {10'h0, 5'h00, r, pdc_pkg::ADDR_REF});
        $display("latch address tests done");
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        xfer(1'b0, pdc_pkg::REG_REF, 32'h0, rd);
        chk_reg(rd, 32'h0000_0000);
        $display("mid-run reset test done");
        test_done();
    end
endmodule // pdc_divider_chain_tb_top

// >>> pdc_far_side.sv
/*
 * Far-side model: reference oscillator, RF source and serial host.
 * Assumes the caller enters each task just after a rising hclk edge.
 */
`timescale 1ns/1ps
module pdc_far_side (
    input  wire logic hclk,
    output logic      reference_in_pin,
    output logic      rf_input,
    output logic      prog_clk_pin,
    output logic      prog_data_pin,
    output logic      latch_strobe
);
    initial begin
        reference_in_pin = 1'b0;
        rf_input         = 1'b0;
        prog_clk_pin     = 1'b0;
        prog_data_pin    = 1'b0;
        latch_strobe     = 1'b0;
    end

    // ------------------------------------------------------------------
    // Oscillators
    // ------------------------------------------------------------------
    // Each phase lasts two bus cycles, far below the comparison limit.
    task automatic edges(input logic rf, input int cnt);
        repeat (cnt) begin
            if (rf) rf_input <= 1'b1;
            else reference_in_pin <= 1'b1;
            repeat (2) @(posedge hclk);
            if (rf) rf_input <= 1'b0;
            else reference_in_pin <= 1'b0;
            repeat (2) @(posedge hclk);
        end
    endtask

    // ------------------------------------------------------------------
    // Serial host
    // ------------------------------------------------------------------
    task automatic send_word(input logic [21:0] w);
        for (int i = 21; i >= 0; i--) begin
            prog_data_pin <= w[i];
            repeat (3) @(posedge hclk);
            prog_clk_pin <= 1'b1;
            repeat (3) @(posedge hclk);
            prog_clk_pin <= 1'b0;
        end
        repeat (3) @(posedge hclk);
        latch_strobe <= 1'b1;
        repeat (3) @(posedge hclk);
        latch_strobe <= 1'b0;
        // The data line is not held after a frame, so it shows junk.
        prog_data_pin <= ~w[0];
        repeat (8) @(posedge hclk);
    endtask
endmodule // pdc_far_side

// >>> pdc_pkg.sv
/*
 * Shared constants of the divider chain: programming word layout,
 * latch addresses, modulus values, register offsets and reset values.
 * Assumes a single 40 MHz bus clock drives every module that uses it.
 */
// Operation
// - Reference divider: 15 bits, ratio 2 to 32767.
// - Reference divider counts buffered reference edges.
// - Comparison rate is reference over ratio.
// - Buffered reference also drives reference output pin.
// - Dual modulus pairs 32/33, 16/17, 8/9.
// - Feedback word bit 20 selects modulus pair.
// - Feedback divider steps on prescaler output only.
// - 13-bit main counter, 5-bit swallow counter.
// - Feedback ratio is base times main plus swallow.
// - 32/33 covers 992 through 262143 gaplessly.
// - 16/17 covers 240 through 131071 gaplessly.
// - 8/9 covers 56 through 65535.
// - Detector compares pulses, drives pump up/down.
// - Locked RF equals feedback ratio times comparison.
// - 22-bit shift register, rising clock, MSB first.
// - Last two bits address latch, strobe loads.
package pdc_pkg;

    // ------------------------------------------------------------------
    // Serial programming word
    // ------------------------------------------------------------------
    localparam int          SHIFT_W  = 22;
    localparam logic [1:0]  ADDR_REF = 2'h0;
    localparam logic [1:0]  ADDR_FB  = 2'h1;
    localparam logic [1:0]  ADDR_AUX = 2'h2;
    localparam logic [21:0] WORD_RST = 22'h00_0000;

    localparam int REF_LSB  = 2;
    localparam int REF_W    = 15;
    localparam int SWL_LSB  = 2;
    localparam int SWL_W    = 5;
    localparam int MAIN_LSB = 7;
    localparam int MAIN_W   = 13;
    localparam int PSEL_BIT = 20;

    localparam logic [15:0] REF_MIN  = 16'h0002;
    localparam logic [15:0] MAIN_MIN = 16'h0001;

    // ------------------------------------------------------------------
    // Prescaler base moduli
    // ------------------------------------------------------------------
    localparam logic [5:0] MOD_32 = 6'h20;
    localparam logic [5:0] MOD_16 = 6'h10;
    localparam logic [5:0] MOD_8  = 6'h08;

    // ------------------------------------------------------------------
    // Bus registers
    // ------------------------------------------------------------------
    localparam logic [31:0] REG_CTRL   = 32'h0000_0000;
    localparam logic [31:0] REG_STATUS = 32'h0000_0004;
    localparam logic [31:0] REG_REF    = 32'h0000_0008;
    localparam logic [31:0] REG_FB     = 32'h0000_000C;
    localparam logic [31:0] REG_AUX    = 32'h0000_0010;
    localparam int          CTRL_RUN_BIT = 0;
    localparam logic        RUN_RST      = 1'b1;

endpackage

// >>> pdc_prog_if.sv
/*
 * Latched programming words passed from the serial port to the chain.
 * Assumes both ends run on the bus clock.
 */
`timescale 1ns/1ps
interface pdc_prog_if;
    logic [21:0] ref_word;
    logic [21:0] fb_word;
    logic [21:0] aux_word;
    logic        load;

    modport src (output ref_word, output fb_word, output aux_word,
                 output load);
    modport dst (input ref_word, input fb_word, input aux_word,
                 input load);
endinterface // pdc_prog_if

// >>> pdc_serial_port.sv
/*
 * Three-wire programming port: shift register and three latches.
 * Assumes the host pins are asynchronous and slow against the bus clock.
 */
`timescale 1ns/1ps
module pdc_serial_port (
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic prog_clk_pin,
    input  wire logic prog_data_pin,
    input  wire logic latch_strobe,
    pdc_prog_if.src   prog
);
    typedef struct packed {
        logic        clk_s1, clk_s2, clk_s3;
        logic        dat_s1, dat_s2;
        logic        le_s1, le_s2, le_s3;
        logic [21:0] shift;
        logic [21:0] ref_word, fb_word, aux_word;
        logic        load;
    } pdc_ser_state_t;

    localparam pdc_ser_state_t ST_RST = '{
        ref_word: pdc_pkg::WORD_RST, fb_word: pdc_pkg::WORD_RST,
        aux_word: pdc_pkg::WORD_RST, default: '0};

    pdc_ser_state_t st_q;
    pdc_ser_state_t st_d;
    logic clk_rise;
    logic le_rise;

    assign clk_rise = st_q.clk_s2 && !st_q.clk_s3;
    assign le_rise  = st_q.le_s2 && !st_q.le_s3;

    always_comb begin
        st_d = st_q;
        st_d.clk_s1 = prog_clk_pin;
        st_d.clk_s2 = st_q.clk_s1;
        st_d.clk_s3 = st_q.clk_s2;
        st_d.dat_s1 = prog_data_pin;
        st_d.dat_s2 = st_q.dat_s1;
        st_d.le_s1  = latch_strobe;
        st_d.le_s2  = st_q.le_s1;
        st_d.le_s3  = st_q.le_s2;
        st_d.load   = 1'b0;
        if (clk_rise) begin
            st_d.shift = {st_q.shift[20:0], st_q.dat_s2};
        end
        if (le_rise) begin
            unique case (st_q.shift[1:0])
                pdc_pkg::ADDR_REF: st_d.ref_word = st_q.shift;
                pdc_pkg::ADDR_FB:  st_d.fb_word  = st_q.shift;
                pdc_pkg::ADDR_AUX: st_d.aux_word = st_q.shift;
                default:           ;
            endcase
            st_d.load = 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q <= ST_RST;
        end else begin
            st_q <= st_d;
        end
    end

    assign prog.ref_word = st_q.ref_word;
    assign prog.fb_word  = st_q.fb_word;
    assign prog.aux_word = st_q.aux_word;
    assign prog.load     = st_q.load;
endmodule // pdc_serial_port
